// ==== rtl/ext_bus_cfg.svh ====
// Summary of operation
// - external bus only when config byte one bits 1 and 0 are both zero.
// - once enabled, every address, internal or external, appears on port0 and port2.
// - data phase of an internal-memory cycle drives port0 to zero.
// - program store strobe reads external program memory only, never data.
// - data memory uses active-low read on P3.7 and store on P3.6.
// - fetches use 16-bit address; data moves use 16-bit or 8-bit address.
// - 8-bit data moves hold the page high byte on port2 the whole cycle.
// - either select bit at zero dedicates P3.6/P3.7 to strobes; port2 leaves I/O only when bit 0 is zero.
// - low address and data share port0; bus pins are push-pull.
// - low address valid on port0 at the falling edge of address latch strobe.
// - write data placed before store strobe falls, held until after it rises.
// - read data sampled just before the read strobe is released.
// - port function selection changes only in programming mode; defaults to I/O.
// - bus access while ports are I/O leaves port pin values unchanged.
// - fetch externally if strap low at reset, or PC beyond internal range while the external bus is enabled.
// - every external fetch puts the PC high byte on port2 when the external bus is enabled.
// - power-on reset samples strobe and latch pins to choose serial, parallel or user mode.
// - programming mode is left by any reset without power-on, or by a power-on reset with user-mode straps.
// - 128 config bytes via index and value registers, writable only when programming.
// - bit 1 zero routes port0 and strobes; bit 0 zero routes port2; default one.
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define ADDR_PAGE_HIGH   8'h92
`define ADDR_CFG_INDEX   8'h93
`define ADDR_CFG_VALUE   8'h94
`define CFG_ONE_INDEX    7'h7e
`define CFG_BIT_PORT0    1
`define CFG_BIT_UPPER    0
`define CFG_RESET_BYTE   8'hff
`define PAGE_RESET       8'h00
`define INDEX_RESET      7'h00
`endif

// ==== rtl/ext_bus_pkg.sv ====
package ext_bus_pkg;
  typedef enum logic [1:0] {
    mode_user,
    mode_serial,
    mode_parallel,
    mode_reserved
  } op_mode_e;
  typedef enum logic [1:0] {
    kind_fetch,
    kind_read,
    kind_write
  } access_kind_e;
endpackage : ext_bus_pkg

// ==== rtl/external_memory_bus_interface.sv ====
`timescale 1ns/10ps
`include "ext_bus_cfg.svh"
module external_memory_bus_interface #(
  parameter int INTERNAL_PROG_BYTES = 32768
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    power_on_reset,
  // special register access from the core
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // core memory request
  input  wire logic                    mem_req,
  input  wire ext_bus_pkg::access_kind_e mem_kind,
  input  wire logic                    mem_short_addr,
  input  wire logic [15:0]             mem_addr,
  input  wire logic [7:0]              mem_wdata,
  input  wire logic                    mem_internal,
  input  wire logic [7:0]              internal_rdata,
  output logic                         mem_ready,
  output logic [7:0]                   mem_rdata,
  output logic                         fetch_external,
  // general-purpose port values from the port latches
  input  wire logic [7:0]              port0_latch,
  input  wire logic [7:0]              port2_latch,
  input  wire logic [1:0]              p3_strobe_latch,
  // port0 pins
  input  wire logic [7:0]              port0_in,
  output logic [7:0]                   port0_out,
  output logic [7:0]                   port0_oe,
  // port2 pins
  output logic [7:0]                   port2_out,
  output logic [7:0]                   port2_oe,
  // strobes; P3.6 store, P3.7 read
  output logic                         store_strobe_b,
  output logic                         read_strobe_b,
  output logic                         strobe_oe,
  // strobe and latch pins, sampled as straps at power-on
  input  wire logic                    program_store_strobe_in,
  input  wire logic                    ale_in,
  input  wire logic                    fetch_source_strap,
  output logic                         program_store_strobe_b,
  output logic                         program_store_strobe_oe,
  output logic                         ale,
  output logic                         ale_oe,
  // mode status
  output ext_bus_pkg::op_mode_e        op_mode
);
  import ext_bus_pkg::*;

  initial begin
    if (INTERNAL_PROG_BYTES < 1 || INTERNAL_PROG_BYTES > 65536) begin
      $error("internal program size out of range");
    end
  end

  // four strobe-low states: the port0 synchroniser needs two of them before the sample
  typedef enum {
    st_idle,
    st_addr,
    st_latch,
    st_strobe,
    st_wait_a,
    st_wait_b,
    st_sample,
    st_hold
  } bus_state_e;

  logic [1:0] sync_pse;
  logic [1:0] sync_ale;
  logic [1:0] sync_ea;
  logic [7:0] port0_sync_a;
  logic [7:0] port0_sync;
  logic       strap_pending;
  logic       ext_fetch_all;
  logic [7:0] page_high;
  logic [6:0] cfg_index;
  logic [7:0] cfg_mem [0:127];
  bus_state_e state;
  bus_state_e next_state;
  logic [15:0]  cyc_addr;
  logic [7:0]   cyc_wdata;
  logic         cyc_internal;
  logic         cyc_short;
  access_kind_e cyc_kind;
  logic [7:0]   rdata_q;
  logic         ready_q;

  // straps go through two flops; every reset release starts strap capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_pse <= 2'h3;
      sync_ale <= 2'h3;
      sync_ea  <= 2'h3;
    end else begin
      sync_pse <= {sync_pse[0], program_store_strobe_in};
      sync_ale <= {sync_ale[0], ale_in};
      sync_ea  <= {sync_ea[0], fetch_source_strap};
    end
  end

  // read data from the pins; only the second stage is read by logic
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port0_sync_a <= 8'h00;
      port0_sync   <= 8'h00;
    end else begin
      port0_sync_a <= port0_in;
      port0_sync   <= port0_sync_a;
    end
  end

  // strap capture waits two edges after release so synchronisers hold pin levels
  logic [1:0] strap_wait;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_pending <= 1'b1;
      strap_wait    <= 2'h0;
      op_mode       <= mode_user;
      ext_fetch_all <= 1'b0;
    end else if (strap_pending) begin
      if (strap_wait == 2'h2) begin
        strap_pending <= 1'b0;
        ext_fetch_all <= !sync_ea[1];
        if (power_on_reset) begin
          unique case ({sync_pse[1], sync_ale[1]})
            2'b01:   op_mode <= mode_serial;
            2'b10:   op_mode <= mode_parallel;
            2'b11:   op_mode <= mode_user;
            default: op_mode <= mode_reserved;
          endcase
        end else begin
          op_mode <= mode_user;
        end
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  wire programming = (op_mode == mode_serial) || (op_mode == mode_parallel);
  wire sel_page  = reg_wr && (reg_addr == `ADDR_PAGE_HIGH);
  wire sel_index = reg_wr && (reg_addr == `ADDR_CFG_INDEX);
  wire sel_value = reg_wr && (reg_addr == `ADDR_CFG_VALUE) && programming;
  wire [7:0] cfg_one = cfg_mem[`CFG_ONE_INDEX];
  wire port0_bus = !cfg_one[`CFG_BIT_PORT0];
  wire port2_bus = !cfg_one[`CFG_BIT_UPPER];
  wire bus_on    = port0_bus && port2_bus;
  wire strobes_on = port0_bus || port2_bus;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_high <= `PAGE_RESET;
      cfg_index <= `INDEX_RESET;
    end else begin
      if (sel_page) begin
        page_high <= reg_wdata;
      end
      if (sel_index) begin
        cfg_index <= reg_wdata[6:0];
      end
    end
  end

  // nonvolatile image is kept in flops; reset models erased defaults
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_cfg
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_mem[gi] <= `CFG_RESET_BYTE;
        end else if (sel_value && cfg_index == 7'(gi)) begin
          cfg_mem[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  wire [7:0] rd_mux = (reg_addr == `ADDR_PAGE_HIGH) ? page_high :
                      (reg_addr == `ADDR_CFG_INDEX) ? {1'b0, cfg_index} :
                      (reg_addr == `ADDR_CFG_VALUE) ? cfg_mem[cfg_index] : 8'h00;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // fetch source decision for the core
  wire beyond_internal = 32'(mem_addr) >= INTERNAL_PROG_BYTES;
  assign fetch_external = ext_fetch_all || (beyond_internal && bus_on);

  // a request while ports are I/O completes internally without touching pins
  wire start_bus = mem_req && bus_on && (state == st_idle);
  wire gpio_done = mem_req && !bus_on && (state == st_idle);

  // fixed-length cycle: slower than a bare strobe, but external read data always clears
  // the two-flop pin synchroniser before it is taken
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (start_bus) begin
          next_state = st_addr;
        end
      end
      st_addr: begin
        next_state = st_latch;
      end
      st_latch: begin
        next_state = st_strobe;
      end
      st_strobe: begin
        next_state = st_wait_a;
      end
      st_wait_a: begin
        next_state = st_wait_b;
      end
      st_wait_b: begin
        next_state = st_sample;
      end
      st_sample: begin
        next_state = st_hold;
      end
      st_hold: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // cycle attributes are frozen at the take
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_addr     <= 16'h0000;
      cyc_wdata    <= 8'h00;
      cyc_internal <= 1'b0;
      cyc_short    <= 1'b0;
      cyc_kind     <= kind_fetch;
    end else if (start_bus) begin
      cyc_addr     <= mem_addr;
      cyc_wdata    <= mem_wdata;
      cyc_internal <= mem_internal;
      cyc_short    <= mem_short_addr && (mem_kind != kind_fetch);
      cyc_kind     <= mem_kind;
    end
  end

  // read data taken while the strobe is still low
  wire       take_sample = (state == st_sample);
  wire [7:0] sample_byte = cyc_internal ? internal_rdata : port0_sync;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      ready_q <= gpio_done || (state == st_hold);
      if (gpio_done) begin
        rdata_q <= internal_rdata;
      end else if (take_sample) begin
        rdata_q <= sample_byte;
      end
    end
  end

  assign mem_ready = ready_q;
  assign mem_rdata = rdata_q;

  wire in_cycle   = (state != st_idle);
  wire addr_phase = (state == st_addr) || (state == st_latch);
  wire strobe_on  = (state == st_strobe) || (state == st_wait_a) ||
                    (state == st_wait_b) || (state == st_sample);
  // store strobe starts one cycle late so write data leads it
  wire write_on   = strobe_on && (state != st_strobe);
  wire is_write   = (cyc_kind == kind_write);
  wire is_fetch   = (cyc_kind == kind_fetch);
  wire is_read    = (cyc_kind == kind_read);
  wire data_drive = is_write || cyc_internal;

  // address high byte or page; internal data never leaves the chip
  wire [7:0] p2_bus  = cyc_short ? page_high : cyc_addr[15:8];
  wire [7:0] p0_data = cyc_internal ? 8'h00 : cyc_wdata;
  wire [7:0] p0_bus  = addr_phase ? cyc_addr[7:0] : p0_data;

  // push-pull drive on the whole byte in bus mode
  wire       p0_drive       = port0_bus && in_cycle && (addr_phase || data_drive);
  wire [7:0] next_port0_out = (port0_bus && in_cycle) ? p0_bus : port0_latch;
  wire [7:0] next_port0_oe  = p0_drive ? 8'hff : 8'h00;
  wire [7:0] next_port2_out = (port2_bus && in_cycle) ? p2_bus : port2_latch;
  wire [7:0] next_port2_oe  = port2_bus ? 8'hff : 8'h00;
  wire       next_ale       = start_bus || (state == st_addr);
  // internal targets show the address but never strobe the external memory
  wire       ext_strobe     = strobe_on && !cyc_internal;
  wire       next_pse_b     = !(ext_strobe && is_fetch);
  wire       next_read_b    = strobes_on ? !(ext_strobe && is_read) : p3_strobe_latch[1];
  wire       next_store_b   = strobes_on ? !(write_on && !cyc_internal && is_write) :
                                           p3_strobe_latch[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port0_out              <= 8'hff;
      port0_oe               <= 8'h00;
      port2_out              <= 8'hff;
      port2_oe               <= 8'h00;
      ale                    <= 1'b0;
      program_store_strobe_b <= 1'b1;
      read_strobe_b          <= 1'b1;
      store_strobe_b         <= 1'b1;
    end else begin
      port0_out              <= next_port0_out;
      port0_oe               <= next_port0_oe;
      port2_out              <= next_port2_out;
      port2_oe               <= next_port2_oe;
      ale                    <= next_ale;
      program_store_strobe_b <= next_pse_b;
      read_strobe_b          <= next_read_b;
      store_strobe_b         <= next_store_b;
    end
  end

  assign strobe_oe = strobes_on;
  // strobe and latch pins only become outputs after straps are taken
  assign program_store_strobe_oe = !strap_pending;
  assign ale_oe = !strap_pending;
endmodule : external_memory_bus_interface

// ==== bench/ext_mem_model.sv ====
`timescale 1ns/10ps
module ext_mem_model (
  // bus pins from the device
  input  wire logic       core_clk,
  input  wire logic       ale,
  input  wire logic [7:0] port0_out,
  input  wire logic [7:0] port2_out,
  input  wire logic       read_strobe_b,
  input  wire logic       store_strobe_b,
  input  wire logic       program_store_strobe_b,
  // data driven back onto port0
  output logic      [7:0] port0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  last = 8'h00;
  wire         rd_on = !read_strobe_b || !program_store_strobe_b;
  // a released bus shows the inverse, so a stale byte never passes as data
  assign port0_in = rd_on ? mem[addr] : ~last;
  always @(negedge ale) addr <= {port2_out, port0_out};
  always @(posedge store_strobe_b) mem[addr] <= port0_out;
  always @(posedge core_clk) if (rd_on) last <= mem[addr];
endmodule : ext_mem_model

// ==== bench/external_memory_bus_interface_checker.sv ====
`timescale 1ns/10ps
module external_memory_bus_interface_checker
  import ext_bus_pkg::*;
#(
  parameter int INTERNAL_PROG_BYTES = 32768
) (
  // watched ports
  input wire logic         core_clk,
  input wire logic         rst_b,
  input wire logic         mem_req,
  input wire access_kind_e mem_kind,
  input wire logic [7:0]   mem_wdata,
  input wire logic         mem_internal,
  input wire logic         mem_ready,
  input wire logic         strobe_oe,
  input wire logic [7:0]   port0_out,
  input wire logic [7:0]   port0_oe,
  input wire logic [7:0]   port2_oe,
  input wire logic         store_strobe_b,
  input wire logic         read_strobe_b,
  input wire logic         program_store_strobe_b,
  input wire logic         ale
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_bus_ready: assert property ($rose(mem_req) && strobe_oe |-> ##8 mem_ready)
    else $error("bus cycle length wrong");
  chk_gpio_ready: assert property ($rose(mem_req) && !strobe_oe |-> ##1 mem_ready)
    else $error("io mode access not answered at once");
  chk_gpio_pins: assert property (!strobe_oe |-> (port0_oe | port2_oe) == 8'h00)
    else $error("port driven while in io mode");
  chk_strobe_idle: assert property (!mem_req && !$past(mem_req)
    |-> store_strobe_b && read_strobe_b && program_store_strobe_b)
    else $error("strobe active outside a cycle");
  chk_ale_addr: assert property ($fell(ale) |-> $stable(port0_out) && port0_oe == 8'hff)
    else $error("address unstable at latch fall");
  chk_write_data: assert property (!store_strobe_b
    |-> mem_kind == kind_write && port0_out == mem_wdata && port0_oe == 8'hff)
    else $error("write data not on port0");
  chk_internal_zero: assert property (mem_internal && $fell(ale) |-> ##1 port0_out == 8'h00)
    else $error("internal data exposed");
  chk_fetch_pse: assert property (!program_store_strobe_b
    |-> mem_kind == kind_fetch && read_strobe_b && store_strobe_b)
    else $error("program strobe on a data move");
  chk_read_strobe: assert property (!read_strobe_b
    |-> mem_kind == kind_read && program_store_strobe_b)
    else $error("read strobe on a non-read");
endmodule : external_memory_bus_interface_checker
bind external_memory_bus_interface external_memory_bus_interface_checker #(
  .INTERNAL_PROG_BYTES(INTERNAL_PROG_BYTES)) u_chk (.core_clk, .rst_b, .mem_req, .mem_kind,
  .mem_wdata, .mem_internal, .mem_ready, .strobe_oe, .port0_out, .port0_oe, .port2_oe,
  .store_strobe_b, .read_strobe_b, .program_store_strobe_b, .ale);

// ==== bench/external_memory_bus_interface_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module external_memory_bus_interface_tb;
  import ext_bus_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, power_on_reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic mem_req = 1'b0, mem_short_addr = 1'b0, mem_internal = 1'b0, fetch_source_strap = 1'b1;
  logic pse_strap = 1'b1, ale_strap = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, mem_wdata = 8'h00, internal_rdata = 8'h3c;
  logic [7:0] port0_latch = 8'hff, port2_latch = 8'hff, d;
  logic [1:0] p3_strobe_latch = 2'h3;
  logic [15:0] mem_addr = 16'h0000;
  access_kind_e mem_kind = kind_read;
  logic [7:0] reg_rdata, mem_rdata, port0_in, port0_out, port0_oe, port2_out, port2_oe;
  logic mem_ready, fetch_external, store_strobe_b, read_strobe_b, strobe_oe, ale, ale_oe;
  logic program_store_strobe_b, program_store_strobe_oe;
  op_mode_e op_mode;
  // strap pins read the device's own drive once it enables them
  wire program_store_strobe_in = program_store_strobe_oe ? program_store_strobe_b : pse_strap;
  wire ale_in = ale_oe ? ale : ale_strap;
  int n_errors = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  external_memory_bus_interface u_external_memory_bus_interface (.core_clk, .rst_b,
    .power_on_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mem_req, .mem_kind,
    .mem_short_addr, .mem_addr, .mem_wdata, .mem_internal, .internal_rdata, .mem_ready,
    .mem_rdata, .fetch_external, .port0_latch, .port2_latch, .p3_strobe_latch, .port0_in,
    .port0_out, .port0_oe, .port2_out, .port2_oe, .store_strobe_b, .read_strobe_b, .strobe_oe,
    .program_store_strobe_in, .ale_in, .fetch_source_strap, .program_store_strobe_b,
    .program_store_strobe_oe, .ale, .ale_oe, .op_mode);
  ext_mem_model u_ext_mem_model (.core_clk, .ale, .port0_out, .port2_out, .read_strobe_b,
    .store_strobe_b, .program_store_strobe_b, .port0_in);
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic do_reset(input logic por, input logic pse, input logic al, input logic fs);
    @(negedge core_clk);
    rst_b = 1'b0;
    power_on_reset = por;
    pse_strap = pse;
    ale_strap = al;
    fetch_source_strap = fs;
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : do_reset
  task automatic reg_w(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : reg_w
  task automatic reg_r(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : reg_r
  task automatic mem_op(input access_kind_e k, input logic sh, input logic [15:0] a,
                        input logic [7:0] w, input logic in, output logic [7:0] r);
    @(negedge core_clk);
    mem_kind = k;
    mem_short_addr = sh;
    mem_addr = a;
    mem_wdata = w;
    mem_internal = in;
    mem_req = 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (mem_ready === 1'b1) break;
      if (i == 19) begin
        n_errors++;
        final_report();
      end
    end
    r = mem_rdata;
    mem_req = 1'b0;
  endtask : mem_op
  task automatic t_defaults;
    do_reset(1'b1, 1'b1, 1'b1, 1'b1);
    `CHK(op_mode, mode_user)
    `CHK({store_strobe_b, read_strobe_b, program_store_strobe_b}, 3'h7)
    `CHK(port0_oe | port2_oe, 8'h00)
    reg_r(8'h92, d);
    `CHK(d, 8'h00)
    reg_r(8'h93, d);
    `CHK(d, 8'h00)
    reg_r(8'h55, d);
    `CHK(d, 8'h00)
  endtask : t_defaults
  task automatic t_user_refuse;
    reg_w(8'h93, 8'h7e);
    reg_w(8'h94, 8'h00);
    reg_r(8'h94, d);
    `CHK(d, 8'hff)
    `CHK(strobe_oe, 1'b0)
    mem_op(kind_write, 1'b0, 16'h1234, 8'h5a, 1'b0, d);
    `CHK(port0_oe | port2_oe, 8'h00)
    mem_op(kind_read, 1'b0, 16'h1234, 8'h00, 1'b0, d);
    `CHK(d, 8'h3c)
  endtask : t_user_refuse
  task automatic t_modes;
    // {power-on, program strobe, latch, expected mode}
    logic [4:0] tbl [5] = '{5'h15, 5'h1a, 5'h1c, 5'h13, 5'h04};
    foreach (tbl[i]) begin
      do_reset(tbl[i][4], tbl[i][3], tbl[i][2], 1'b1);
      `CHK(op_mode, op_mode_e'(tbl[i][1:0]))
    end
  endtask : t_modes
  task automatic t_bus;
    do_reset(1'b1, 1'b0, 1'b1, 1'b1);
    reg_w(8'h93, 8'h7e);
    reg_w(8'h94, 8'h00);
    reg_r(8'h94, d);
    `CHK(d, 8'h00)
    `CHK(strobe_oe, 1'b1)
    reg_w(8'h92, 8'ha5);
    mem_op(kind_write, 1'b0, 16'h1234, 8'h5a, 1'b0, d);
    `CHK(u_ext_mem_model.mem[16'h1234], 8'h5a)
    u_ext_mem_model.mem[16'ha534] = 8'hc3;
    mem_op(kind_read, 1'b1, 16'h0034, 8'h00, 1'b0, d);
    `CHK(d, 8'hc3)
    u_ext_mem_model.mem[16'h9abc] = 8'h77;
    mem_op(kind_fetch, 1'b0, 16'h9abc, 8'h00, 1'b0, d);
    `CHK(d, 8'h77)
    `CHK(fetch_external, 1'b1)
    mem_op(kind_read, 1'b0, 16'h0200, 8'h00, 1'b1, d);
    `CHK(d, 8'h3c)
    mem_addr = 16'h0010;
    #1 `CHK(fetch_external, 1'b0)
  endtask : t_bus
  task automatic t_strap;
    do_reset(1'b1, 1'b1, 1'b1, 1'b0);
    mem_addr = 16'h0010;
    #1 `CHK(fetch_external, 1'b1)
  endtask : t_strap
  initial begin
    t_defaults();
    t_user_refuse();
    t_modes();
    t_bus();
    t_strap();
    final_report();
  end
endmodule : external_memory_bus_interface_tb
